// ### rtl/pif_irq_flags.sv
// peripheral interrupt enable and request registers with axi4-lite access
// assumes timers, captures, port b and serial units run on ref_clk_in
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module pif_irq_flags
	import pif_pkg::*;
#(
	parameter int PORT_W = 4
) (
	input  wire logic              ref_clk_in,
	input  wire logic              sys_rst_in,
	input  wire logic [7:0]        s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	input  wire logic [7:0]        s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	input  wire logic [PORT_W-1:0] port_b_monitor_in,
	input  wire logic              capture1_pin_in,
	input  wire logic              capture2_pin_in,
	input  wire logic [15:0]       timer3_count_in,
	input  wire logic [15:0]       timer3_period_pair_in,
	input  wire logic [7:0]        timer2_count_in,
	input  wire logic [7:0]        timer2_period_in,
	input  wire logic [7:0]        timer1_count_in,
	input  wire logic [7:0]        timer1_period_in,
	input  wire logic              serial1_tx_empty_in,
	input  wire logic              serial1_rx_full_in,
	input  wire logic [4:0]        req_two_event_in,
	input  wire logic              serial2_tx_empty_in,
	input  wire logic              serial2_rx_full_in,
	output logic                   periph_summary_flag_out,
	output logic                   irq_out
);
	// ==========================================================
	// registers
	logic [7:0]        periph_int_enable_two;
	logic [7:0]        periph_int_enable_one;
	logic [7:0]        periph_int_request_one;
	logic [7:0]        periph_int_request_two;
	logic [2:0]        config_bits;
	logic [PORT_W-1:0] port_ref;
	logic              timer1_width_select;
	logic              capture1_period3_select;
	logic              global_irq_disable;

	assign timer1_width_select     = config_bits[BIT_T1_WIDTH];
	assign capture1_period3_select = config_bits[BIT_CAP1_PER3];
	assign global_irq_disable      = config_bits[BIT_GLB_DIS];

	// ==========================================================
	// axi4-lite write path
	logic       aw_full;
	logic       w_full;
	logic [5:0] aw_idx;
	logic [7:0] w_byte;
	logic       w_lane0;
	logic       wr_fire;
	logic       wr_en_two;
	logic       wr_en_one;
	logic       wr_req_one;
	logic       wr_req_two;
	logic       wr_config;
	logic       wr_mapped;

	assign s_axi_awready_out = !aw_full && !s_axi_bvalid_out;
	assign s_axi_wready_out  = !w_full && !s_axi_bvalid_out;
	assign wr_fire           = aw_full && w_full;
	assign wr_en_two         = wr_fire && w_lane0 && aw_idx == IDX_EN_TWO;
	assign wr_en_one         = wr_fire && w_lane0 && aw_idx == IDX_EN_ONE;
	assign wr_req_one        = wr_fire && w_lane0 && aw_idx == IDX_REQ_ONE;
	assign wr_req_two        = wr_fire && w_lane0 && aw_idx == IDX_REQ_TWO;
	assign wr_config         = wr_fire && w_lane0 && aw_idx == IDX_CONFIG;
	assign wr_mapped         = aw_idx inside {IDX_EN_TWO, IDX_EN_ONE, IDX_REQ_ONE, IDX_REQ_TWO, IDX_CONFIG,
		IDX_PORT_REF, IDX_SUMMARY};

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			aw_full <= 1'b0;
			aw_idx  <= 6'h00;
		end else if (wr_fire) begin
			aw_full <= 1'b0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_full <= 1'b1;
			aw_idx  <= s_axi_awaddr_in[7:ADDR_LSB];
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			w_full  <= 1'b0;
			w_byte  <= RST_BYTE;
			w_lane0 <= 1'b0;
		end else if (wr_fire) begin
			w_full <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_full  <= 1'b1;
			w_byte  <= s_axi_wdata_in[7:0];
			w_lane0 <= s_axi_wstrb_in[0];
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// ==========================================================
	// enables and configuration
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			periph_int_enable_two <= RST_BYTE;
			periph_int_enable_one <= RST_BYTE;
			config_bits           <= RST_CONFIG;
		end else begin
			if (wr_en_two)
				periph_int_enable_two <= w_byte & IMPL_MASK_TWO;
			if (wr_en_one)
				periph_int_enable_one <= w_byte;
			if (wr_config)
				config_bits <= w_byte[2:0];
		end
	end

	// ==========================================================
	// event detection from the peripherals' own state
	logic [15:0]       t3_prev;
	logic [7:0]        t2_prev;
	logic [7:0]        t1_prev;
	logic              cap1_prev;
	logic              cap2_prev;
	logic              port_mismatch;
	logic              t3_event;
	logic              t2_event;
	logic              t1_event;
	logic              cap1_event;
	logic              cap2_event;
	logic [7:0]        set_one;

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			t3_prev   <= ZERO16;
			t2_prev   <= RST_BYTE;
			t1_prev   <= RST_BYTE;
			cap1_prev <= 1'b0;
			cap2_prev <= 1'b0;
		end else begin
			t3_prev   <= timer3_count_in;
			t2_prev   <= timer2_count_in;
			t1_prev   <= timer1_count_in;
			cap1_prev <= capture1_pin_in;
			cap2_prev <= capture2_pin_in;
		end
	end

	// rollover means last count matched the limit and the count is now zero
	assign t3_event = timer3_count_in == ZERO16 &&
		(capture1_period3_select ? t3_prev == ALL16 : t3_prev == timer3_period_pair_in);
	assign t2_event = timer2_count_in == RST_BYTE && t2_prev == timer2_period_in;
	assign t1_event = timer1_width_select ?
		({timer2_count_in, timer1_count_in} == ZERO16 &&
		 {t2_prev, t1_prev} == {timer2_period_in, timer1_period_in}) :
		(timer1_count_in == RST_BYTE && t1_prev == timer1_period_in);
	// capture event taken as a rising edge on the shared pin
	assign cap1_event    = capture1_pin_in && !cap1_prev;
	assign cap2_event    = capture2_pin_in && !cap2_prev;
	assign port_mismatch = port_b_monitor_in != port_ref;

	always_comb begin
		set_one                  = RST_BYTE;
		set_one[BIT_PORT_CHANGE] = port_mismatch;
		set_one[BIT_TIMER3]      = t3_event;
		set_one[BIT_TIMER2]      = t2_event;
		set_one[BIT_TIMER1]      = t1_event;
		set_one[BIT_CAPTURE2]    = cap2_event;
		set_one[BIT_CAPTURE1]    = cap1_event;
	end

	// ==========================================================
	// request flags: set wins over a write-one-to-clear in the same cycle
	logic [7:0] clr_one;
	logic [7:0] clr_two;
	logic [7:0] set_two;

	assign clr_one = wr_req_one ? (w_byte & ~HW_MASK_SER) : RST_BYTE;
	assign clr_two = wr_req_two ? (w_byte & ~HW_MASK_SER & IMPL_MASK_TWO) : RST_BYTE;
	assign set_two = {req_two_event_in[4:2], 1'b0, req_two_event_in[1:0], 2'b00};

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			periph_int_request_one <= RST_BYTE;
		end else begin
			// enables and global disable are not consulted here
			periph_int_request_one[7:2] <= (periph_int_request_one[7:2] & ~clr_one[7:2]) | set_one[7:2];
			periph_int_request_one[BIT_SER_TX] <= serial1_tx_empty_in;
			periph_int_request_one[BIT_SER_RX] <= serial1_rx_full_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			periph_int_request_two <= RST_BYTE;
		end else begin
			periph_int_request_two[7:2] <= ((periph_int_request_two[7:2] & ~clr_two[7:2]) | set_two[7:2])
				& IMPL_MASK_TWO[7:2];
			periph_int_request_two[1] <= serial2_tx_empty_in;
			periph_int_request_two[0] <= serial2_rx_full_in;
		end
	end

	// ==========================================================
	// summary and interrupt output
	assign periph_summary_flag_out = |(periph_int_request_one & periph_int_enable_one) |
		|(periph_int_request_two & periph_int_enable_two);
	assign irq_out = periph_summary_flag_out && !global_irq_disable;

	// ==========================================================
	// axi4-lite read path; reading the port reference re-arms the mismatch
	logic       rd_take;
	logic [5:0] ar_idx;
	logic [7:0] rd_byte;
	logic       rd_mapped;

	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign rd_take           = s_axi_arvalid_in && s_axi_arready_out;
	assign ar_idx            = s_axi_araddr_in[7:ADDR_LSB];

	always_comb begin
		rd_byte   = RST_BYTE;
		rd_mapped = 1'b1;
		case (ar_idx)
			IDX_EN_TWO:   rd_byte = periph_int_enable_two;
			IDX_EN_ONE:   rd_byte = periph_int_enable_one;
			IDX_REQ_ONE:  rd_byte = periph_int_request_one;
			IDX_REQ_TWO:  rd_byte = periph_int_request_two;
			IDX_CONFIG:   rd_byte = {5'h00, config_bits};
			IDX_PORT_REF: rd_byte = 8'(port_b_monitor_in);
			IDX_SUMMARY:  rd_byte = {7'h00, periph_summary_flag_out};
			default:      rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h0000_0000;
			s_axi_rresp_out  <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out  <= {24'h00_0000, rd_byte};
			s_axi_rresp_out  <= rd_mapped ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// software ends the mismatch only by reading the port, as the port does
	always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			port_ref <= '0;
		else if (rd_take && ar_idx == IDX_PORT_REF)
			port_ref <= port_b_monitor_in;
	end

	// ==========================================================
	// checks
	property p_en_two_unused;
		@(posedge ref_clk_in) disable iff (sys_rst_in) periph_int_enable_two[BIT_UNUSED_TWO] == 1'b0;
	endproperty
	a_en_two_unused: assert property (p_en_two_unused) else $error("enable two bit 4 set");

	property p_req_two_unused;
		@(posedge ref_clk_in) disable iff (sys_rst_in) periph_int_request_two[BIT_UNUSED_TWO] == 1'b0;
	endproperty
	a_req_two_unused: assert property (p_req_two_unused) else $error("request two bit 4 set");

	property p_en_two_write;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			wr_en_two |=> periph_int_enable_two == ($past(w_byte) & IMPL_MASK_TWO);
	endproperty
	a_en_two_write: assert property (p_en_two_write) else $error("enable two write lost");

	property p_ser_tx;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			##1 periph_int_request_one[BIT_SER_TX] == $past(serial1_tx_empty_in);
	endproperty
	a_ser_tx: assert property (p_ser_tx) else $error("tx flag does not follow buffer");

	property p_ser_rx;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			wr_req_one |=> periph_int_request_one[BIT_SER_RX] == $past(serial1_rx_full_in);
	endproperty
	a_ser_rx: assert property (p_ser_rx) else $error("rx flag moved by write");

	property p_cap1;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			$rose(capture1_pin_in) |=> periph_int_request_one[BIT_CAPTURE1];
	endproperty
	a_cap1: assert property (p_cap1) else $error("capture1 flag not set");

	property p_cap2;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			$rose(capture2_pin_in) |=> periph_int_request_one[BIT_CAPTURE2];
	endproperty
	a_cap2: assert property (p_cap2) else $error("capture2 flag not set");

	property p_t2;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			timer2_count_in == RST_BYTE && $past(timer2_count_in) == timer2_period_in
			|=> periph_int_request_one[BIT_TIMER2];
	endproperty
	a_t2: assert property (p_t2) else $error("timer2 flag not set");

	property p_t3_ovf;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			timer3_count_in == ZERO16 && (capture1_period3_select ? $past(timer3_count_in) == ALL16 :
			$past(timer3_count_in) == timer3_period_pair_in)
			|=> periph_int_request_one[BIT_TIMER3];
	endproperty
	a_t3_ovf: assert property (p_t3_ovf) else $error("timer3 overflow missed");

	property p_t1_16;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			(timer1_width_select ? {timer2_count_in, timer1_count_in} == ZERO16 &&
			$past(timer2_count_in) == timer2_period_in && $past(timer1_count_in) == timer1_period_in :
			timer1_count_in == RST_BYTE && $past(timer1_count_in) == timer1_period_in)
			|=> periph_int_request_one[BIT_TIMER1];
	endproperty
	a_t1_16: assert property (p_t1_16) else $error("timer1 flag not set");

	property p_port;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			port_mismatch [*2] |-> periph_int_request_one[BIT_PORT_CHANGE];
	endproperty
	a_port: assert property (p_port) else $error("port change flag clear during mismatch");

	property p_irq;
		@(posedge ref_clk_in) disable iff (sys_rst_in)
			irq_out == (periph_summary_flag_out && !config_bits[BIT_GLB_DIS]) &&
			periph_summary_flag_out == ((periph_int_request_one & periph_int_enable_one |
			periph_int_request_two & periph_int_enable_two) != 8'h00);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without enabled flag");
endmodule : pif_irq_flags

// ### rtl/pif_pkg.sv
// peripheral interrupt enable and request bookkeeping: shared constants
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package pif_pkg;
	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_REQ_TWO  = 6'h10;
	localparam logic [5:0] IDX_EN_TWO   = 6'h11;
	localparam logic [5:0] IDX_REQ_ONE  = 6'h16;
	localparam logic [5:0] IDX_EN_ONE   = 6'h17;
	localparam logic [5:0] IDX_CONFIG   = 6'h20;
	localparam logic [5:0] IDX_PORT_REF = 6'h21;
	localparam logic [5:0] IDX_SUMMARY  = 6'h22;
	localparam int         ADDR_LSB     = 2;
	// ==========================================================
	// request one layout
	localparam int BIT_PORT_CHANGE = 7;
	localparam int BIT_TIMER3      = 6;
	localparam int BIT_TIMER2      = 5;
	localparam int BIT_TIMER1      = 4;
	localparam int BIT_CAPTURE2    = 3;
	localparam int BIT_CAPTURE1    = 2;
	localparam int BIT_SER_TX      = 1;
	localparam int BIT_SER_RX      = 0;
	// enable two / request two layout
	localparam int BIT_UNUSED_TWO  = 4;
	localparam logic [7:0] IMPL_MASK_TWO = 8'hef;
	localparam logic [7:0] HW_MASK_SER   = 8'h03;
	// ==========================================================
	// config register fields
	localparam int BIT_T1_WIDTH  = 0;
	localparam int BIT_CAP1_PER3 = 1;
	localparam int BIT_GLB_DIS   = 2;
	// ==========================================================
	// reset values and answers
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [2:0]  RST_CONFIG = 3'h0;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam logic [15:0] ZERO16     = 16'h0000;
	localparam logic [15:0] ALL16      = 16'hffff;
endpackage : pif_pkg

// ### test/peripheral_irq_enable_flags_test.sv
// register-level bench for the peripheral flag block over axi4-lite
// assumes one 125 MHz clock; timers come from the model, other sources from the bench
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module peripheral_irq_enable_flags_test;
	import pif_pkg::*;
	localparam logic [7:0] T2P = 8'h07;
	localparam logic [7:0] T1P = 8'h05;
	logic        ref_clk_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdat = 8'h00;
	logic        aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
	logic [3:0]  port = 4'h0;
	logic        cap1 = 1'b0, cap2 = 1'b0, tx1 = 1'b0, rx1 = 1'b0, tx2 = 1'b0, rx2 = 1'b0;
	logic [4:0]  ev = 5'h00;
	logic [1:0]  run = 2'h0;
	logic        pair = 1'b0;
	logic [15:0] t3p = 16'h0100;
	logic [15:0] t3;
	logic [7:0]  t2, t1, rd;
	logic        awr, wrr, bv, arr, rv, summ, irq;
	logic [1:0]  bresp, rresp, rs;
	logic [31:0] rdata;
	logic [7:0]  cfg_t [5] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'h02};
	logic [1:0]  run_t [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
	logic [15:0] p3_t  [5] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'hffff};
	logic [7:0]  m_t   [5] = '{8'h40, 8'h40, 8'h30, 8'h10, 8'h40};
	logic [7:0]  e_t   [5] = '{8'h00, 8'h40, 8'h30, 8'h10, 8'h40};
	int          errors = 0;
	int          tests_run = 0;

	always #4 ref_clk_in = ~ref_clk_in;

	pif_irq_flags #(.PORT_W(4)) DUT (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(addr), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(awr),
		.s_axi_wdata_in({24'h000000, wdat}), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(wrr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(b_rdy),
		.s_axi_araddr_in(addr), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(arr), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(r_rdy), .port_b_monitor_in(port),
		.capture1_pin_in(cap1), .capture2_pin_in(cap2), .timer3_count_in(t3), .timer3_period_pair_in(t3p),
		.timer2_count_in(t2), .timer2_period_in(T2P), .timer1_count_in(t1), .timer1_period_in(T1P),
		.serial1_tx_empty_in(tx1), .serial1_rx_full_in(rx1), .req_two_event_in(ev),
		.serial2_tx_empty_in(tx2), .serial2_rx_full_in(rx2), .periph_summary_flag_out(summ), .irq_out(irq));

	pif_timer_model u_tmr (.clk_in(ref_clk_in), .run_in(run), .pair_in(pair), .t3p_in(t3p),
		.t2p_in(T2P), .t1p_in(T1P), .t3_out(t3), .t2_out(t2), .t1_out(t1));

	// ==========================================================
	// bus tasks
	task automatic summarize();
		$display("counts: tests_run=%0d errors=%0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] s);
		int n;
		@(posedge ref_clk_in);
		addr <= a;
		wdat <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_rdy <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk_in);
			if (awr) aw_v <= 1'b0;
			if (wrr) w_v <= 1'b0;
			if (bv) break;
		end
		b_rdy <= 1'b0;
		s = bresp;
		if (n == 40) begin
			errors++;
			summarize();
		end
	endtask : wr

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic [1:0] s);
		int n;
		@(posedge ref_clk_in);
		addr <= a;
		ar_v <= 1'b1;
		r_rdy <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge ref_clk_in);
			if (arr) ar_v <= 1'b0;
			if (rv) break;
		end
		r_rdy <= 1'b0;
		d = rdata[7:0];
		`CHK(rdata[31:8], 24'h000000)
		s = rresp;
		if (n == 40) begin
			errors++;
			summarize();
		end
	endtask : rd_reg

	task automatic wo(input logic [7:0] a, input logic [7:0] d);
		logic [1:0] s;
		wr(a, d, s);
		`CHK(s, RESP_OKAY)
	endtask : wo

	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] s;
		rd_reg(a, d, s);
		`CHK(d & m, e)
		`CHK(s, RESP_OKAY)
	endtask : rchk

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask : idle

	// ==========================================================
	// test sequence
	initial begin
		repeat (10) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		rchk(8'h44, 8'hff, 8'h00);
		rchk(8'h58, 8'hff, 8'h00);
		wo(8'h44, 8'hff);
		rchk(8'h44, 8'hff, 8'hef);
		wo(8'h44, 8'h00);
		$display("test enable layout done");
		// flags must latch with every enable clear and the global disable set
		wo(8'h80, 8'h04);
		cap1 <= 1'b1;
		idle(2);
		rchk(8'h58, 8'h0c, 8'h04);
		cap2 <= 1'b1;
		idle(2);
		rchk(8'h58, 8'h0c, 8'h0c);
		wo(8'h58, 8'h0c);
		rchk(8'h58, 8'h0c, 8'h00);
		$display("test captures done");
		tx1 <= 1'b1;
		idle(2);
		rchk(8'h58, 8'h03, 8'h02);
		wo(8'h58, 8'h03);
		rchk(8'h58, 8'h03, 8'h02);
		tx1 <= 1'b0;
		rx1 <= 1'b1;
		idle(2);
		rchk(8'h58, 8'h03, 8'h01);
		rx1 <= 1'b0;
		$display("test serial flags done");
		port <= 4'h5;
		idle(2);
		rchk(8'h58, 8'h80, 8'h80);
		wo(8'h58, 8'h80);
		rchk(8'h58, 8'h80, 8'h80);
		rchk(8'h84, 8'h0f, 8'h05);
		wo(8'h58, 8'h80);
		rchk(8'h58, 8'h80, 8'h00);
		$display("test port change done");
		for (int i = 0; i < 5; i++) begin
			wo(8'h80, cfg_t[i]);
			t3p <= p3_t[i];
			pair <= cfg_t[i][0];
			idle(2);
			wo(8'h58, 8'h70);
			run <= run_t[i];
			idle(12);
			run <= 2'h0;
			rchk(8'h58, m_t[i], e_t[i]);
		end
		$display("test timers done");
		// stale flags are cleared before the enable goes up
		wo(8'h80, 8'h00);
		wo(8'h58, 8'hff);
		tx1 <= 1'b1;
		wo(8'h5c, 8'h02);
		idle(1);
		`CHK(summ, 1'b1)
		`CHK(irq, 1'b1)
		rchk(8'h88, 8'h01, 8'h01);
		wo(8'h80, 8'h04);
		idle(1);
		`CHK(irq, 1'b0)
		`CHK(summ, 1'b1)
		wo(8'h5c, 8'h00);
		idle(1);
		`CHK(summ, 1'b0)
		tx1 <= 1'b0;
		$display("test interrupt done");
		ev <= 5'h1f;
		tx2 <= 1'b1;
		rx2 <= 1'b1;
		idle(1);
		ev <= 5'h00;
		idle(2);
		rchk(8'h40, 8'hff, 8'hef);
		wo(8'h44, 8'h80);
		idle(1);
		`CHK(summ, 1'b1)
		wo(8'h40, 8'hff);
		rchk(8'h40, 8'hff, 8'h03);
		wo(8'h44, 8'h00);
		$display("test request two done");
		wr(8'hfc, 8'h55, rs);
		`CHK(rs, RESP_SLV)
		rd_reg(8'hfc, rd, rs);
		`CHK(rs, RESP_SLV)
		`CHK(rd, 8'h00)
		$display("test unmapped done");
		summarize();
	end

	initial begin
		repeat (20000) @(posedge ref_clk_in);
		errors++;
		summarize();
	end
endmodule : peripheral_irq_enable_flags_test

// ### test/pif_timer_model.sv
// timer units facing the flag block: up counters that roll to zero after matching their period
// assumes the bench sets periods and run bits; a stopped counter parks just below its limit
`timescale 1ns/1ps
module pif_timer_model (
	input  wire logic        clk_in,
	input  wire logic [1:0]  run_in,
	input  wire logic        pair_in,
	input  wire logic [15:0] t3p_in,
	input  wire logic [7:0]  t2p_in,
	input  wire logic [7:0]  t1p_in,
	output logic      [15:0] t3_out,
	output logic      [7:0]  t2_out,
	output logic      [7:0]  t1_out
);
	// ==========================================================
	// parking near the limit keeps every rollover a few cycles away, so runs stay short
	always_ff @(posedge clk_in) begin
		if (!run_in[0]) begin
			{t2_out, t1_out} <= pair_in ? {t2p_in, t1p_in} - 16'h0002 : {t2p_in - 8'h02, t1p_in - 8'h02};
		end else if (pair_in) begin
			{t2_out, t1_out} <= ({t2_out, t1_out} == {t2p_in, t1p_in}) ? 16'h0000 : {t2_out, t1_out} + 16'h0001;
		end else begin
			t1_out <= (t1_out == t1p_in) ? 8'h00 : t1_out + 8'h01;
			t2_out <= (t2_out == t2p_in) ? 8'h00 : t2_out + 8'h01;
		end
	end

	// a period of all ones makes the match and the natural overflow the same edge
	always_ff @(posedge clk_in) begin
		if (!run_in[1]) begin
			t3_out <= t3p_in - 16'h0003;
		end else begin
			t3_out <= (t3_out == t3p_in) ? 16'h0000 : t3_out + 16'h0001;
		end
	end
endmodule : pif_timer_model
